// ---- rtl/fieldbus_status_indicators.sv ----
// Status lamps, frame address handling and ring closing of a fieldbus slave
// Notes on behaviour
// R1 - Flicker: 50 ms lit, 50 ms dark, repeating at 10 Hz.
// R2 - Blink: 200 ms lit, 200 ms dark, repeating at 2.5 Hz.
// R3 - Single flash: 200 ms lit, then 1000 ms dark, repeating.
// R4 - Double flash: lit, gap, lit, each 200 ms, then 1000 ms dark.
// R5 - Link lamp dark while its port is closed, link or not.
// R6 - Link lamp flickers with port open, link up and traffic.
// R7 - Link lamp steady with port open, link up, no traffic.
// R8 - State lamp: dark, blink, single, steady, flicker per state.
// R9 - Fault lamp: dark, flicker on flash load, blink config, single local.
// R10 - Fault lamp double flash on watchdog, steady on memory error.
// R11 - Address field is 32 bits, node part and offset part.
// R12 - Position: 16-bit node part incremented on pass, zero selects us.
// R13 - Fixed: node part matched to assigned node address.
// R14 - Logical: window inside the shared 32-bit space is read and written.
// R15 - Node address set by the master's scan, no user setting.
// R16 - Ring closed internally when no downstream partner is present.
// R17 - 100 Mbit/s full duplex; upstream and downstream ports distinct.
// R18 - All patterns counted from one shared millisecond tick.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_status_indicators
  import fieldbus_status_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic supply_ok_i,
  input wire logic [1:0] port_open_i,
  input wire logic [1:0] link_i,
  input wire logic [1:0] act_i,
  input wire logic [3:0] sm_state_i,
  input wire logic err_flash_i,
  input wire logic err_cfg_i,
  input wire logic err_local_i,
  input wire logic err_wdog_i,
  input wire logic err_mem_i,
  input wire logic frm_valid_i,
  input wire logic [1:0] frm_kind_i,
  input wire logic [31:0] frm_addr_i,
  input wire logic frm_set_node_i,
  input wire logic [15:0] frm_data_i,
  input wire logic [31:0] log_start_i,
  input wire logic [31:0] log_len_i,
  input wire logic down_present_i,
  output logic [1:0] la_lamp_o,
  output logic state_lamp_o,
  output logic supply_lamp_o,
  output logic fault_lamp_o,
  output logic frm_done_o,
  output logic hit_o,
  output logic [31:0] fwd_addr_o,
  output logic [31:0] offset_o,
  output logic [15:0] node_addr_o,
  output logic loop_close_o
);
  localparam int TICK_W = $clog2(MS_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [10:0] fl_cnt;
    logic [10:0] bl_cnt;
    logic [10:0] sf_cnt;
    logic [10:0] df_cnt;
    logic sup_s1;
    logic sup_s2;
    logic [1:0] act_seen;
    logic [1:0] act_win;
    logic [1:0] la_lamp;
    logic state_lamp;
    logic supply_lamp;
    logic fault_lamp;
    logic done;
    logic hit;
    logic [31:0] fwd_addr;
    logic [31:0] offset;
    logic [15:0] node_addr;
    logic loop_close;
  } state_type;

  state_type st;
  state_type next_st;
  logic fl_lvl;
  logic bl_lvl;
  logic sf_lvl;
  logic df_lvl;
  logic fl_wrap;
  pattern_type state_pat;
  pattern_type fault_pat;
  pattern_type la_pat [2];

  function automatic logic [10:0] wrap_inc(
    input logic [10:0] cnt,
    input logic [10:0] per
  );
    if (cnt == per - 11'h001) begin
      return 11'h000;
    end
    return cnt + 11'h001;
  endfunction

  function automatic logic pat_level(
    input pattern_type p,
    input logic [3:0] lv
  );
    case (p)
      PAT_OFF: return 1'b0;
      PAT_ON: return 1'b1;
      PAT_FLICK: return lv[0];
      PAT_BLINK: return lv[1];
      PAT_SINGLE: return lv[2];
      PAT_DOUBLE: return lv[3];
      default: return 1'b0;
    endcase
  endfunction

  // Lit phases of each pattern, all from the shared counters
  always_comb begin
    fl_lvl = st.fl_cnt < FLICK_ON_MS; // R1
    bl_lvl = st.bl_cnt < BLINK_ON_MS; // R2
    sf_lvl = st.sf_cnt < FLASH_ON_MS; // R3
    df_lvl = (st.df_cnt < FLASH_ON_MS) || // R4
      ((st.df_cnt >= FLASH_ON_MS + FLASH_GAP_MS) &&
       (st.df_cnt < FLASH_ON_MS + FLASH_GAP_MS + FLASH_ON_MS));
    fl_wrap = st.tick && (st.fl_cnt == FLICK_PER - 11'h001);
  end

  // Pattern choice per lamp
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!port_open_i[i] || !link_i[i]) begin
        la_pat[i] = PAT_OFF; // R5
      end else if (st.act_win[i] || st.act_seen[i]) begin
        la_pat[i] = PAT_FLICK; // R6
      end else begin
        la_pat[i] = PAT_ON; // R7
      end
    end
    case (sm_state_i) // R8
      SM_INIT: state_pat = PAT_OFF;
      SM_PREOP: state_pat = PAT_BLINK;
      SM_SAFEOP: state_pat = PAT_SINGLE;
      SM_OP: state_pat = PAT_ON;
      SM_BOOT: state_pat = PAT_FLICK;
      default: state_pat = PAT_OFF;
    endcase
    // Most severe error wins
    if (err_mem_i) begin
      fault_pat = PAT_ON; // R10
    end else if (err_flash_i) begin
      fault_pat = PAT_FLICK; // R9
    end else if (err_cfg_i) begin
      fault_pat = PAT_BLINK; // R9
    end else if (err_wdog_i) begin
      fault_pat = PAT_DOUBLE; // R10
    end else if (err_local_i) begin
      fault_pat = PAT_SINGLE; // R9
    end else begin
      fault_pat = PAT_OFF; // R9
    end
  end

  always_comb begin
    next_st = st;
    // Millisecond tick shared by all lamps except the supply lamp
    next_st.tick = 1'b0;
    if (st.tick_cnt == TICK_LAST) begin
      next_st.tick_cnt = '0; // R18
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + TICK_W'(1);
    end
    if (st.tick) begin
      next_st.fl_cnt = wrap_inc(st.fl_cnt, FLICK_PER); // R1
      next_st.bl_cnt = wrap_inc(st.bl_cnt, BLINK_PER); // R2
      next_st.sf_cnt = wrap_inc(st.sf_cnt, SINGLE_PER); // R3
      next_st.df_cnt = wrap_inc(st.df_cnt, DOUBLE_PER); // R4
    end
    next_st.sup_s1 = supply_ok_i;
    next_st.sup_s2 = st.sup_s1;
    // Traffic is judged per flicker period; a pulse at the wrap is kept
    if (fl_wrap) begin
      next_st.act_win = st.act_seen | act_i; // R6
      next_st.act_seen = 2'h0;
    end else begin
      next_st.act_seen = st.act_seen | act_i;
    end
    for (int i = 0; i < 2; i++) begin
      next_st.la_lamp[i] = pat_level(la_pat[i], {df_lvl, sf_lvl, bl_lvl, fl_lvl});
    end
    next_st.state_lamp = pat_level(state_pat, {df_lvl, sf_lvl, bl_lvl, fl_lvl});
    next_st.fault_lamp = pat_level(fault_pat, {df_lvl, sf_lvl, bl_lvl, fl_lvl});
    next_st.supply_lamp = st.sup_s2;
    // Frame address handling
    next_st.done = frm_valid_i;
    if (frm_valid_i) begin
      next_st.offset = {16'h0000, frm_addr_i[OFFS_LSB +: OFFS_W]}; // R11
      next_st.fwd_addr = frm_addr_i;
      case (frm_kind_i)
        ADDR_POS: begin
          next_st.fwd_addr[NODE_LSB +: NODE_W] = frm_addr_i[NODE_LSB +: NODE_W] + 16'h0001; // R12
          next_st.hit = frm_addr_i[NODE_LSB +: NODE_W] == 16'h0000; // R12
          if (frm_set_node_i && (frm_addr_i[NODE_LSB +: NODE_W] == 16'h0000)) begin
            next_st.node_addr = frm_data_i; // R15
          end
        end
        ADDR_FIX: begin
          next_st.hit = frm_addr_i[NODE_LSB +: NODE_W] == st.node_addr; // R13
        end
        ADDR_LOG: begin
          next_st.offset = frm_addr_i - log_start_i; // R14
          next_st.hit = (frm_addr_i - log_start_i) < log_len_i; // R14
        end
        default: begin
          next_st.hit = 1'b0;
        end
      endcase
    end else begin
      next_st.hit = 1'b0;
    end
    next_st.loop_close = !down_present_i; // R16
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign la_lamp_o = st.la_lamp;
  assign state_lamp_o = st.state_lamp;
  assign supply_lamp_o = st.supply_lamp;
  assign fault_lamp_o = st.fault_lamp;
  assign frm_done_o = st.done;
  assign hit_o = st.hit;
  assign fwd_addr_o = st.fwd_addr;
  assign offset_o = st.offset;
  assign node_addr_o = st.node_addr;
  assign loop_close_o = st.loop_close; // R17

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_ms_step;
    st.tick ##1 !st.tick;
  endsequence

  property p_flick;
    st.tick && st.fl_cnt == FLICK_ON_MS - 11'h001 |=> !fl_lvl ##0 st.fl_cnt == FLICK_ON_MS;
  endproperty
  a_flick: assert property (p_flick) else $error("flicker phase wrong"); // R1

  property p_blink;
    st.tick && st.bl_cnt == BLINK_PER - 11'h001 |=> bl_lvl && st.bl_cnt == 11'h000;
  endproperty
  a_blink: assert property (p_blink) else $error("blink period wrong"); // R2

  property p_single;
    st.tick && st.sf_cnt == FLASH_ON_MS - 11'h001 |=> !sf_lvl;
  endproperty
  a_single: assert property (p_single) else $error("single flash too long"); // R3

  property p_double;
    st.tick && st.df_cnt == FLASH_ON_MS + FLASH_GAP_MS - 11'h001 |=> df_lvl;
  endproperty
  a_double: assert property (p_double) else $error("second flash missing"); // R4

  property p_la_closed;
    !port_open_i[UP_PORT] |=> !la_lamp_o[UP_PORT];
  endproperty
  a_la_closed: assert property (p_la_closed) else $error("lamp lit on closed port"); // R5

  property p_la_idle;
    port_open_i[DOWN_PORT] && link_i[DOWN_PORT] && !st.act_win[DOWN_PORT] && !st.act_seen[DOWN_PORT]
      |=> la_lamp_o[DOWN_PORT];
  endproperty
  a_la_idle: assert property (p_la_idle) else $error("idle link lamp not steady"); // R7

  property p_tick_gap;
    s_ms_step |-> !st.tick [*2];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent"); // R18

  property p_state_op;
    sm_state_i == SM_OP |=> state_lamp_o;
  endproperty
  a_state_op: assert property (p_state_op) else $error("state lamp not steady"); // R8

  property p_no_fault;
    !(err_mem_i || err_flash_i || err_cfg_i || err_wdog_i || err_local_i) |=> !fault_lamp_o;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("fault lamp without error"); // R9

  property p_mem_fault;
    err_mem_i |=> fault_lamp_o;
  endproperty
  a_mem_fault: assert property (p_mem_fault) else $error("memory error not shown"); // R10

  property p_pos;
    frm_valid_i && frm_kind_i == ADDR_POS |=> frm_done_o &&
      fwd_addr_o[15:0] == $past(frm_addr_i[15:0]) + 16'h0001 &&
      hit_o == ($past(frm_addr_i[15:0]) == 16'h0000);
  endproperty
  a_pos: assert property (p_pos) else $error("position handling wrong"); // R12

  property p_fix;
    frm_valid_i && frm_kind_i == ADDR_FIX |=> hit_o == ($past(frm_addr_i[15:0]) == $past(node_addr_o));
  endproperty
  a_fix: assert property (p_fix) else $error("fixed match wrong"); // R13

  property p_ring;
    1'b1 |=> loop_close_o == !$past(down_present_i);
  endproperty
  a_ring: assert property (p_ring) else $error("ring close wrong"); // R16
endmodule
`default_nettype wire

// ---- rtl/fieldbus_status_pkg.sv ----
// Constants for the fieldbus status indicator and addressing block
package fieldbus_status_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int LINK_MBPS = 100;
  localparam logic [10:0] FLICK_ON_MS = 11'h032;
  localparam logic [10:0] FLICK_OFF_MS = 11'h032;
  localparam logic [10:0] BLINK_ON_MS = 11'h0C8;
  localparam logic [10:0] BLINK_OFF_MS = 11'h0C8;
  localparam logic [10:0] FLASH_ON_MS = 11'h0C8;
  localparam logic [10:0] FLASH_GAP_MS = 11'h0C8;
  localparam logic [10:0] FLASH_LONG_MS = 11'h3E8;
  localparam logic [10:0] FLICK_PER = FLICK_ON_MS + FLICK_OFF_MS;
  localparam logic [10:0] BLINK_PER = BLINK_ON_MS + BLINK_OFF_MS;
  localparam logic [10:0] SINGLE_PER = FLASH_ON_MS + FLASH_LONG_MS;
  localparam logic [10:0] DOUBLE_PER = FLASH_ON_MS + FLASH_GAP_MS + FLASH_ON_MS + FLASH_LONG_MS;
  localparam int NODE_LSB = 0;
  localparam int NODE_W = 16;
  localparam int OFFS_LSB = 16;
  localparam int OFFS_W = 16;
  localparam logic [1:0] ADDR_POS = 2'h0;
  localparam logic [1:0] ADDR_FIX = 2'h1;
  localparam logic [1:0] ADDR_LOG = 2'h2;
  localparam logic [3:0] SM_INIT = 4'h1;
  localparam logic [3:0] SM_PREOP = 4'h2;
  localparam logic [3:0] SM_BOOT = 4'h3;
  localparam logic [3:0] SM_SAFEOP = 4'h4;
  localparam logic [3:0] SM_OP = 4'h8;
  localparam int UP_PORT = 0;
  localparam int DOWN_PORT = 1;
  localparam logic [15:0] NODE_RESET = 16'h0000;
  typedef enum logic [5:0] {
    PAT_OFF = 6'h01,
    PAT_ON = 6'h02,
    PAT_FLICK = 6'h04,
    PAT_BLINK = 6'h08,
    PAT_SINGLE = 6'h10,
    PAT_DOUBLE = 6'h20
  } pattern_type;
endpackage

// ---- sim/fieldbus_master_model.sv ----
// Network master model presenting frame address fields
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model (
  input wire logic sys_clk_i,
  output logic frm_valid_o,
  output logic [1:0] frm_kind_o,
  output logic [31:0] frm_addr_o,
  output logic frm_set_node_o,
  output logic [15:0] frm_data_o
);
  initial begin
    frm_valid_o = 1'b0;
    frm_kind_o = 2'h3;
    frm_addr_o = 32'h0;
    frm_set_node_o = 1'b0;
    frm_data_o = 16'h0;
  end
  // One address field per call, one cycle long; lines are scrambled afterwards
  task automatic send(input logic [1:0] kind, input logic [31:0] addr, input logic set, input logic [15:0] data);
    @(posedge sys_clk_i);
    frm_valid_o <= 1'b1;
    frm_kind_o <= kind;
    frm_addr_o <= addr;
    frm_set_node_o <= set;
    frm_data_o <= data;
    @(posedge sys_clk_i);
    frm_valid_o <= 1'b0;
    frm_kind_o <= ~kind;
    frm_addr_o <= ~addr;
    frm_set_node_o <= 1'b0;
    frm_data_o <= ~data;
  endtask
endmodule
`default_nettype wire

// ---- sim/fieldbus_status_indicators_test.sv ----
// Self-checking bench for the fieldbus status block
`timescale 1ns/1ps
`default_nettype none
module fieldbus_status_indicators_test;
  import fieldbus_status_pkg::*;
  localparam int MSC = 10;
  localparam int FP = int'(FLICK_PER) * MSC;
  localparam int FL = int'(FLICK_ON_MS) * MSC;
  localparam int BP = int'(BLINK_PER) * MSC;
  localparam int BL = int'(BLINK_ON_MS) * MSC;
  localparam int SP = int'(SINGLE_PER) * MSC;
  localparam int SL = int'(FLASH_ON_MS) * MSC;
  localparam int DP = int'(DOUBLE_PER) * MSC;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic supply_ok = 1'b0;
  logic [1:0] port_open = 2'h0;
  logic [1:0] link = 2'h0;
  logic [1:0] act = 2'h0;
  logic [3:0] sm_state = SM_INIT;
  logic [4:0] err = 5'h00;
  logic down_present = 1'b1;
  logic frm_valid, frm_set_node, state_lamp, supply_lamp, fault_lamp, frm_done, hit, loop_close;
  logic [1:0] frm_kind, la_lamp;
  logic [31:0] frm_addr, fwd_addr, offset;
  logic [15:0] frm_data, node_addr;
  int failures = 0;
  int checks_done = 0;
  always #2 sys_clk = ~sys_clk;
  fieldbus_master_model mm (.sys_clk_i(sys_clk), .frm_valid_o(frm_valid), .frm_kind_o(frm_kind),
    .frm_addr_o(frm_addr), .frm_set_node_o(frm_set_node), .frm_data_o(frm_data));
  fieldbus_status_indicators #(.MS_CYCLES(MSC)) dut (.sys_clk_i(sys_clk), .nrst_i(nrst),
    .supply_ok_i(supply_ok), .port_open_i(port_open), .link_i(link), .act_i(act), .sm_state_i(sm_state),
    .err_flash_i(err[0]), .err_cfg_i(err[1]), .err_local_i(err[2]), .err_wdog_i(err[3]), .err_mem_i(err[4]),
    .frm_valid_i(frm_valid), .frm_kind_i(frm_kind), .frm_addr_i(frm_addr), .frm_set_node_i(frm_set_node),
    .frm_data_i(frm_data), .log_start_i(32'h0001_0000), .log_len_i(32'h0000_0100),
    .down_present_i(down_present), .la_lamp_o(la_lamp), .state_lamp_o(state_lamp),
    .supply_lamp_o(supply_lamp), .fault_lamp_o(fault_lamp), .frm_done_o(frm_done), .hit_o(hit),
    .fwd_addr_o(fwd_addr), .offset_o(offset), .node_addr_o(node_addr), .loop_close_o(loop_close));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Counts lit cycles and turn-on events of one lamp over exactly per cycles
  task automatic meas(input int sel, input int per, input int lit, input int rises);
    logic [4:0] v;
    logic prev;
    int n;
    int r;
    n = 0;
    r = 0;
    repeat (3) @(posedge sys_clk);
    // Lamps are read just after the edge that launched them
    #1;
    v = {supply_lamp, la_lamp, fault_lamp, state_lamp};
    prev = v[sel];
    for (int i = 0; i < per; i++) begin
      @(posedge sys_clk);
      #1;
      v = {supply_lamp, la_lamp, fault_lamp, state_lamp};
      n += int'(v[sel] === 1'b1);
      r += int'(v[sel] === 1'b1 && prev !== 1'b1);
      prev = v[sel];
    end
    // Return on an edge so that the caller drives inputs there
    @(posedge sys_clk);
    chk("lit cycles", n, lit);
    chk("turn-ons", r, rises);
  endtask
  task automatic frame(input logic [1:0] kind, input logic [31:0] addr, input logic set, input logic [15:0] data,
                       input logic eh, input logic [31:0] ef, input logic [31:0] eo);
    mm.send(kind, addr, set, data);
    #1;
    chk("frame done", frm_done, 1'b1);
    chk("hit", hit, eh);
    if (kind == ADDR_POS) chk("forward address", fwd_addr, ef);
    if (kind != 2'h3) chk("offset", offset, eo);
  endtask
  task automatic t_frames;
    frame(ADDR_POS, 32'h0005_0000, 1'b1, 16'h1234, 1'b1, 32'h0005_0001, 32'h5);
    chk("node address", node_addr, 32'h1234);
    frame(ADDR_POS, 32'h0009_FFFE, 1'b0, 16'h0, 1'b0, 32'h0009_FFFF, 32'h9);
    frame(ADDR_POS, 32'h0000_FFFF, 1'b0, 16'h0, 1'b0, 32'h0, 32'h0);
    frame(ADDR_POS, 32'h0000_0002, 1'b1, 16'h5555, 1'b0, 32'h3, 32'h0);
    chk("node address kept", node_addr, 32'h1234);
    frame(ADDR_FIX, 32'h0007_1234, 1'b0, 16'h0, 1'b1, 32'h0, 32'h7);
    frame(ADDR_FIX, 32'h0007_1235, 1'b0, 16'h0, 1'b0, 32'h0, 32'h7);
    frame(ADDR_LOG, 32'h0001_0010, 1'b0, 16'h0, 1'b1, 32'h0, 32'h10);
    frame(ADDR_LOG, 32'h0001_0100, 1'b0, 16'h0, 1'b0, 32'h0, 32'h100);
    frame(2'h3, 32'h0, 1'b0, 16'h0, 1'b0, 32'h0, 32'h0);
  endtask
  task automatic t_ring_supply;
    @(posedge sys_clk);
    down_present <= 1'b0;
    supply_ok <= 1'b1;
    meas(4, 100, 100, 0);
    chk("ring closed", loop_close, 1'b1);
    down_present <= 1'b1;
    supply_ok <= 1'b0;
    meas(4, 100, 0, 0);
    chk("ring open", loop_close, 1'b0);
  endtask
  task automatic t_state;
    sm_state <= SM_INIT;
    meas(0, 200, 0, 0);
    sm_state <= SM_PREOP;
    meas(0, BP, BL, 1);
    sm_state <= SM_SAFEOP;
    meas(0, SP, SL, 1);
    sm_state <= SM_OP;
    meas(0, 200, 200, 0);
    sm_state <= SM_BOOT;
    meas(0, FP, FL, 1);
  endtask
  task automatic t_link;
    port_open <= 2'b01;
    link <= 2'b11;
    act <= 2'b11;
    meas(2, FP, FL, 1);
    meas(3, 200, 0, 0);
    act <= 2'b00;
    repeat (2 * FP) @(posedge sys_clk);
    meas(2, 200, 200, 0);
    port_open <= 2'b10;
    meas(3, 200, 200, 0);
    meas(2, 200, 0, 0);
  endtask
  task automatic t_fault;
    err <= 5'h01;
    meas(1, FP, FL, 1);
    err <= 5'h02;
    meas(1, BP, BL, 1);
    err <= 5'h04;
    meas(1, SP, SL, 1);
    err <= 5'h08;
    meas(1, DP, 2 * SL, 2);
    err <= 5'h10;
    meas(1, 200, 200, 0);
    err <= 5'h00;
    meas(1, 200, 0, 0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("node address at reset", node_addr, NODE_RESET);
    t_frames;
    t_ring_supply;
    t_state;
    t_link;
    t_fault;
    tally_and_finish;
  end
  initial begin
    #400000;
    failures++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
